// ---- hw/tmb_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module tmb_timer
    import tmb_pkg::*;
(
    input  wire logic ref_clk,    // System clock
    input  wire logic rstn,       // Async reset, active low
    input  wire logic ce,         // Clock enable, freezes state when low
    input  wire logic ext_tick,   // External clock pulse, one cycle per edge
    input  wire logic gate_pin,   // Gate pin level
    tmb_link_if.dev   link        // Link to controller
);

    ////////////////////////////////////////////////////////////////////////
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [15:0] cc_q;
    logic        flag_q;
    logic        match_q;
    logic        tick_q;
    logic        wake_q;
    logic        vec_q;
    logic        cmp_evt_q;

    logic        counter_on;
    logic        clock_source_select;
    logic        sync_select;
    logic        gate_enable;
    logic        gate_invert;
    logic        async_mode;
    logic        run_ok;
    logic        src_tick;
    logic        gate_sel;
    logic        gate_ok;
    logic        inc;
    logic        match;
    logic        sev;
    logic        cnt_wr;
    logic        wrap;
    logic        wake_cond;
    logic        cmp_mode;
    logic        spec_mode;
    logic        cap_mode;
    logic [1:0]  cnt_lane_wr;
    logic [1:0]  cc_lane_wr;
    logic [15:0] cnt_wr_val;
    logic [15:0] cc_wr_val;

    assign counter_on          = link.timer_control_reg[CTL_COUNTER_ON];
    assign clock_source_select = link.timer_control_reg[CTL_CLK_SRC];
    assign sync_select         = link.timer_control_reg[CTL_SYNC_SEL];
    assign gate_enable         = link.timer_control_reg[CTL_GATE_EN];
    assign gate_invert         = link.timer_control_reg[CTL_GATE_INV];
    assign cmp_mode            = (link.cc_mode == CC_COMPARE) | (link.cc_mode == CC_SPECIAL);
    assign spec_mode           = (link.cc_mode == CC_SPECIAL);
    assign cap_mode            = (link.cc_mode == CC_CAPTURE);

    ////////////////////////////////////////////////////////////////////////
    // Increment qualification
    // Only the unsynchronised external count keeps running in sleep;
    // the system clock path is assumed stopped there.
    assign async_mode = clock_source_select & sync_select;
    assign run_ok     = ~link.sleep | async_mode;
    assign src_tick   = clock_source_select ? ext_tick : 1'b1;
    assign gate_sel   = link.gate_src_sel ? link.second_comparator_out : gate_pin;
    // Gate is active low unless inverted
    assign gate_ok    = ~gate_enable | (gate_invert ? gate_sel : ~gate_sel);
    assign inc        = counter_on & src_tick & run_ok & gate_ok;

    ////////////////////////////////////////////////////////////////////////
    // Compare and special event
    assign match  = cmp_mode & (count_q == cc_q);
    assign sev    = match & spec_mode;
    assign cnt_wr = link.cnt_wr_lo | link.cnt_wr_hi;
    assign wrap   = inc & ~cnt_wr & ~sev & (count_q == CNT_MAX);

    // Byte lanes: a write replaces its own byte only, the other half is not latched
    assign cnt_lane_wr = {link.cnt_wr_hi, link.cnt_wr_lo};
    assign cc_lane_wr  = {link.cc_wr_hi, link.cc_wr_lo};
    for (genvar b = 0; b < 2; b++) begin : g_lane
        assign cnt_wr_val[8*b +: 8] = cnt_lane_wr[b] ? link.wr_data : count_q[8*b +: 8];
        assign cc_wr_val[8*b +: 8]  = cc_lane_wr[b] ? link.wr_data : cc_q[8*b +: 8];
    end

    always_comb begin
        count_d = count_q;
        if (cnt_wr) begin
            count_d = cnt_wr_val;
        end else if (sev) begin
            count_d = CNT_RESET;
        end else if (inc) begin
            count_d = count_q + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            count_q <= CNT_RESET;
        end else if (ce) begin
            count_q <= count_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Capture/compare register pair
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cc_q <= CNT_RESET;
        end else if (ce) begin
            // Capture wins over a byte write in the same cycle
            if (link.cap_evt && cap_mode) begin
                cc_q <= count_q;
            end else if (|cc_lane_wr) begin
                cc_q <= cc_wr_val;
            end
        end
    end

    // One event per arrival at the match value, not one per cycle held
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            match_q   <= 1'b0;
            cmp_evt_q <= 1'b0;
        end else if (ce) begin
            match_q   <= match;
            cmp_evt_q <= match & ~match_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Rollover flag: a wrap in the clearing cycle wins over the clear
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            flag_q <= 1'b0;
        end else if (ce) begin
            if (wrap) begin
                flag_q <= 1'b1;
            end else if (link.flag_clr) begin
                flag_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wake from sleep on overflow
    assign wake_cond = link.sleep & wrap & counter_on
                       & link.rollover_irq_enable & link.peripheral_irq_enable;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wake_q <= 1'b0;
        end else if (ce) begin
            wake_q <= wake_cond;
        end
    end

    // Branch to the vector only when the global enable is also set
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            vec_q <= 1'b0;
        end else if (ce) begin
            vec_q <= wake_cond & link.global_irq_enable;
        end
    end

    // Increment clock for comparator resampling
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tick_q <= 1'b0;
        end else if (ce) begin
            tick_q <= inc;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign link.count         = count_q;
    assign link.cc_val        = cc_q;
    assign link.rollover_flag = flag_q;
    assign link.irq_req       = flag_q & link.rollover_irq_enable
                                & link.peripheral_irq_enable & link.global_irq_enable;
    assign link.wake          = wake_q;
    assign link.vector_branch = vec_q;
    assign link.cmp_evt       = cmp_evt_q;
    assign link.inc_tick      = tick_q;

endmodule
`default_nettype wire

// ---- hw/tmb_pkg.sv ----
package tmb_pkg;
    localparam int          CNT_W          = 16;
    localparam logic [15:0] CNT_RESET      = 16'h0000;
    localparam logic [15:0] CNT_MAX        = 16'hffff;
    localparam logic [15:0] IRQ_VECTOR     = 16'h0004;
    localparam logic [7:0]  BYTE_RESET     = 8'h00;

    // Timer control register fields
    localparam int          CTL_COUNTER_ON = 0;
    localparam int          CTL_CLK_SRC    = 1;
    localparam int          CTL_SYNC_SEL   = 2;
    localparam int          CTL_OSC_EN     = 3;
    localparam int          CTL_GATE_EN    = 6;
    localparam int          CTL_GATE_INV   = 7;

    // Capture/compare modes
    localparam logic [1:0]  CC_OFF         = 2'h0;
    localparam logic [1:0]  CC_CAPTURE     = 2'h1;
    localparam logic [1:0]  CC_COMPARE     = 2'h2;
    localparam logic [1:0]  CC_SPECIAL     = 2'h3;

    // Controller register offsets
    localparam logic [3:0]  REG_CTRL       = 4'h0;
    localparam logic [3:0]  REG_CNT_LO     = 4'h1;
    localparam logic [3:0]  REG_CNT_HI     = 4'h2;
    localparam logic [3:0]  REG_FLAG       = 4'h3;
    localparam logic [3:0]  REG_ENABLE     = 4'h4;
    localparam logic [3:0]  REG_IRQ_CTL    = 4'h5;
    localparam logic [3:0]  REG_CC_LO      = 4'h6;
    localparam logic [3:0]  REG_CC_HI      = 4'h7;
    localparam logic [3:0]  REG_CC_CTL     = 4'h8;

    // Flag / enable / irq control / cc control fields
    localparam int          FLG_ROLLOVER   = 0;
    localparam int          FLG_CC         = 1;
    localparam int          IRQ_PERIPH     = 6;
    localparam int          IRQ_GLOBAL     = 7;
    localparam int          CCC_GATE_SRC   = 2;
    localparam int          CCC_CMP_SYNC   = 3;
endpackage

// ---- hw/tmb_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface tmb_link_if;
    logic [7:0]  timer_control_reg;
    logic        cnt_wr_lo;
    logic        cnt_wr_hi;
    logic        cc_wr_lo;
    logic        cc_wr_hi;
    logic [7:0]  wr_data;
    logic        flag_clr;
    logic        rollover_irq_enable;
    logic        peripheral_irq_enable;
    logic        global_irq_enable;
    logic [1:0]  cc_mode;
    logic        cap_evt;
    logic        gate_src_sel;
    logic        second_comparator_out;
    logic        sleep;
    logic [15:0] count;
    logic [15:0] cc_val;
    logic        rollover_flag;
    logic        irq_req;
    logic        wake;
    logic        vector_branch;
    logic        cmp_evt;
    logic        inc_tick;

    modport dev (
        input  timer_control_reg, cnt_wr_lo, cnt_wr_hi, cc_wr_lo, cc_wr_hi, wr_data, flag_clr,
               rollover_irq_enable, peripheral_irq_enable, global_irq_enable, cc_mode, cap_evt,
               gate_src_sel, second_comparator_out, sleep,
        output count, cc_val, rollover_flag, irq_req, wake, vector_branch, cmp_evt, inc_tick
    );
    modport host (
        output timer_control_reg, cnt_wr_lo, cnt_wr_hi, cc_wr_lo, cc_wr_hi, wr_data, flag_clr,
               rollover_irq_enable, peripheral_irq_enable, global_irq_enable, cc_mode, cap_evt,
               gate_src_sel, second_comparator_out, sleep,
        input  count, cc_val, rollover_flag, irq_req, wake, vector_branch, cmp_evt, inc_tick
    );
endinterface
`default_nettype wire

// ---- hw/tmb_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module tmb_ctrl
    import tmb_pkg::*;
(
    input  wire logic        ref_clk,    // System clock
    input  wire logic        rstn,       // Async reset, active low
    input  wire logic        ce,         // Clock enable
    input  wire logic [3:0]  addr,       // Register address
    input  wire logic [7:0]  wdata,      // Write data
    input  wire logic        wr,         // Write strobe
    input  wire logic        rd,         // Read strobe
    output logic      [7:0]  rdata,      // Read data, cycle after rd
    input  wire logic        sleep_req,  // Core is asleep
    input  wire logic        cmp_raw,    // Second comparator raw output
    input  wire logic        cap_in,     // Capture input, rising edge
    output logic             irq,        // Combined interrupt request
    output logic             wake,       // Wake pulse
    output logic [15:0]      vector,     // Vector address, valid with vector_go
    output logic             vector_go,  // Branch-to-vector pulse
    tmb_link_if.host         link        // Link to timer
);

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] ctrl_q;
    logic [1:0] enable_q;
    logic [1:0] irqc_q;
    logic [3:0] ccc_q;
    logic       ccflag_q;
    logic       cap_q;
    logic       cmp_q;
    logic [7:0] rdata_q;
    logic [7:0] rd_d;
    logic       flag_wr;

    assign flag_wr = wr && addr == REG_FLAG;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q   <= BYTE_RESET;
            enable_q <= 2'h0;
            irqc_q   <= 2'h0;
            ccc_q    <= 4'h0;
        end else if (ce && wr) begin
            case (addr)
                REG_CTRL:    ctrl_q   <= wdata;
                REG_ENABLE:  enable_q <= wdata[1:0];
                REG_IRQ_CTL: irqc_q   <= wdata[7:6];
                REG_CC_CTL:  ccc_q    <= wdata[3:0];
                default:     ;
            endcase
        end
    end

    // Compare/capture flag: a new event beats a clearing write
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ccflag_q <= 1'b0;
            cap_q    <= 1'b0;
        end else if (ce) begin
            cap_q <= cap_in;
            if (link.cmp_evt || link.cap_evt) begin
                ccflag_q <= 1'b1;
            end else if (flag_wr && !wdata[FLG_CC]) begin
                ccflag_q <= 1'b0;
            end
        end
    end

    // Comparator gate resampled on the timer's increment clock
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cmp_q <= 1'b0;
        end else if (ce && link.inc_tick) begin
            cmp_q <= cmp_raw;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        rd_d = BYTE_RESET;
        case (addr)
            REG_CTRL:    rd_d = ctrl_q;
            REG_CNT_LO:  rd_d = link.count[7:0];
            REG_CNT_HI:  rd_d = link.count[15:8];
            REG_FLAG:    rd_d = {6'h00, ccflag_q, link.rollover_flag};
            REG_ENABLE:  rd_d = {6'h00, enable_q};
            REG_IRQ_CTL: rd_d = {irqc_q, 6'h00};
            REG_CC_LO:   rd_d = link.cc_val[7:0];
            REG_CC_HI:   rd_d = link.cc_val[15:8];
            REG_CC_CTL:  rd_d = {4'h0, ccc_q};
            default:     rd_d = BYTE_RESET;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= BYTE_RESET;
        end else if (ce) begin
            rdata_q <= rd ? rd_d : BYTE_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign link.timer_control_reg     = ctrl_q;
    assign link.cnt_wr_lo             = ce & wr & (addr == REG_CNT_LO);
    assign link.cnt_wr_hi             = ce & wr & (addr == REG_CNT_HI);
    assign link.cc_wr_lo              = ce & wr & (addr == REG_CC_LO);
    assign link.cc_wr_hi              = ce & wr & (addr == REG_CC_HI);
    assign link.wr_data               = wdata;
    assign link.flag_clr              = ce & flag_wr & ~wdata[FLG_ROLLOVER];
    assign link.rollover_irq_enable   = enable_q[FLG_ROLLOVER];
    assign link.peripheral_irq_enable = irqc_q[IRQ_PERIPH - 6];
    assign link.global_irq_enable     = irqc_q[IRQ_GLOBAL - 6];
    assign link.cc_mode               = ccc_q[1:0];
    assign link.cap_evt               = ce & cap_in & ~cap_q & (ccc_q[1:0] == CC_CAPTURE);
    assign link.gate_src_sel          = ccc_q[CCC_GATE_SRC];
    assign link.second_comparator_out = ccc_q[CCC_CMP_SYNC] ? cmp_q : cmp_raw;
    assign link.sleep                 = sleep_req;

    assign rdata     = rdata_q;
    assign irq       = link.irq_req
                       | (ccflag_q & enable_q[FLG_CC] & irqc_q[0] & irqc_q[1]);
    assign wake      = link.wake;
    assign vector    = IRQ_VECTOR;
    assign vector_go = link.vector_branch;

endmodule
`default_nettype wire

// ---- tb/tmb_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module tmb_monitor
    import tmb_pkg::*;
(
    input  wire logic        ref_clk,               // clock
    input  wire logic        rstn,                  // reset
    input  wire logic [7:0]  timer_control_reg,     // control
    input  wire logic        cnt_wr_lo,             // count lo write
    input  wire logic        cnt_wr_hi,             // count hi write
    input  wire logic [7:0]  wr_data,               // write byte
    input  wire logic        flag_clr,              // flag clear
    input  wire logic        rollover_irq_enable,   // ie
    input  wire logic        peripheral_irq_enable, // peripheral_irq_enable
    input  wire logic        global_irq_enable,     // gie
    input  wire logic [1:0]  cc_mode,               // cc mode
    input  wire logic        cap_evt,               // capture
    input  wire logic        gate_src_sel,          // gate source
    input  wire logic        second_comparator_out, // comparator
    input  wire logic        sleep,                 // asleep
    input  wire logic [15:0] count,                 // count
    input  wire logic [15:0] cc_val,                // cc value
    input  wire logic        rollover_flag,         // flag
    input  wire logic        irq_req,               // irq
    input  wire logic        cmp_evt,               // compare
    input  wire logic        inc_tick               // increment
);
    logic match_now;
    logic spec_now;
    logic match_q;
    logic spec_q;
    logic wr_q;
    assign match_now = cc_mode[1] && (count == cc_val);
    assign spec_now  = (cc_mode == CC_SPECIAL) && (count == cc_val);
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            match_q <= 1'b0;
            spec_q  <= 1'b0;
            wr_q    <= 1'b0;
        end else begin
            match_q <= match_now;
            spec_q  <= spec_now;
            wr_q    <= cnt_wr_lo | cnt_wr_hi;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // Writes and special clears move the count by other means, so they are set aside
    property p_step; inc_tick && !wr_q && !spec_q |-> count == $past(count) + 16'h1; endproperty
    a_step: assert property (p_step) else $error("count step wrong");
    property p_hold; !inc_tick && !wr_q && !spec_q |-> $stable(count); endproperty
    a_hold: assert property (p_hold) else $error("count moved without tick");
    property p_wrap; inc_tick && !wr_q && !spec_q && $past(count) == CNT_MAX |-> rollover_flag; endproperty
    a_wrap: assert property (p_wrap) else $error("wrap left flag clear");
    property p_src; $rose(rollover_flag) |-> inc_tick && !wr_q && !spec_q && $past(count) == CNT_MAX; endproperty
    a_src: assert property (p_src) else $error("flag set without wrap");
    property p_sticky; rollover_flag && !flag_clr |=> rollover_flag; endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped");
    property p_irq;
        irq_req == (rollover_flag && rollover_irq_enable && peripheral_irq_enable && global_irq_enable);
    endproperty
    a_irq: assert property (p_irq) else $error("irq request wrong");
    property p_sleep; sleep && !(timer_control_reg[CTL_CLK_SRC] && timer_control_reg[CTL_SYNC_SEL]) |=> !inc_tick;
    endproperty
    a_sleep: assert property (p_sleep) else $error("counted in sleep");
    property p_gate;
        timer_control_reg[CTL_GATE_EN] && gate_src_sel &&
        (second_comparator_out != timer_control_reg[CTL_GATE_INV]) |=> !inc_tick;
    endproperty
    a_gate: assert property (p_gate) else $error("counted with gate closed");
    property p_clear; spec_now && !cnt_wr_lo && !cnt_wr_hi |=> count == CNT_RESET; endproperty
    a_clear: assert property (p_clear) else $error("special clear missing");
    property p_wrlo; cnt_wr_lo |=> count[7:0] == $past(wr_data); endproperty
    a_wrlo: assert property (p_wrlo) else $error("count write lost");
    property p_cmp; match_now && !match_q |=> cmp_evt; endproperty
    a_cmp: assert property (p_cmp) else $error("compare event missing");
    property p_cap; cap_evt && cc_mode == CC_CAPTURE |=> cc_val == $past(count); endproperty
    a_cap: assert property (p_cap) else $error("capture value wrong");
    c_wrap: cover property (inc_tick && count == CNT_RESET && rollover_flag);
    c_special: cover property (spec_now);
    c_capture: cover property (cap_evt);
    c_compare: cover property (cmp_evt);
endmodule
`default_nettype wire

// ---- tb/tmb_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tmb_tb
    import tmb_pkg::*;
;
    logic        ref_clk, rstn, ce, ext_tick, gate_pin, bus_wr, bus_rd, sleep_req, cmp_raw, cap_in, rd_seen;
    logic        irq, wake, vector_go;
    logic [3:0]  addr;
    logic [7:0]  wdata, rdata, r8;
    logic [15:0] vector, vec_seen, start;
    logic [31:0] rnd;
    logic [7:0]  expq[$];
    int          failures, checked, cyc, wake_n, vgo_n, cmp_n;

    tmb_link_if link ();
    tmb_timer tmb_timer_i (.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .ext_tick(ext_tick),
                           .gate_pin(gate_pin), .link(link));
    tmb_ctrl tmb_ctrl_i (.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata),
                         .wr(bus_wr), .rd(bus_rd), .rdata(rdata), .sleep_req(sleep_req), .cmp_raw(cmp_raw),
                         .cap_in(cap_in), .irq(irq), .wake(wake), .vector(vector), .vector_go(vector_go),
                         .link(link));
    tmb_monitor tmb_monitor_i (
        .ref_clk(ref_clk), .rstn(rstn), .timer_control_reg(link.timer_control_reg),
        .cnt_wr_lo(link.cnt_wr_lo), .cnt_wr_hi(link.cnt_wr_hi), .wr_data(link.wr_data),
        .flag_clr(link.flag_clr), .rollover_irq_enable(link.rollover_irq_enable),
        .peripheral_irq_enable(link.peripheral_irq_enable), .global_irq_enable(link.global_irq_enable),
        .cc_mode(link.cc_mode), .cap_evt(link.cap_evt), .gate_src_sel(link.gate_src_sel),
        .second_comparator_out(link.second_comparator_out), .sleep(link.sleep), .count(link.count),
        .cc_val(link.cc_val), .rollover_flag(link.rollover_flag), .irq_req(link.irq_req),
        .cmp_evt(link.cmp_evt), .inc_tick(link.inc_tick));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic give_verdict();
        if (failures == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Strobes stay up between back-to-back calls; idle and tick drop them
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        bus_wr <= w;
        bus_rd <= !w;
        addr   <= a;
        wdata  <= d;
        if (!w) expq.push_back(d);
        @(posedge ref_clk);
    endtask

    task automatic idle(input int n);
        bus_wr <= 1'b0;
        bus_rd <= 1'b0;
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic tick(input int n);
        bus_wr <= 1'b0;
        bus_rd <= 1'b0;
        repeat (n) begin
            ext_tick <= 1'b1;
            @(posedge ref_clk);
            ext_tick <= 1'b0;
            @(posedge ref_clk);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk) begin
        rd_seen <= bus_rd && rstn;
        cyc++;
        if (wake) wake_n++;
        if (link.cmp_evt) cmp_n++;
        if (vector_go) begin
            vgo_n++;
            vec_seen = vector;
        end
        if (cyc == 20000) begin
            failures++;
            give_verdict();
        end
    end

    // Read data stands only in the cycle after the strobe, so look mid-cycle
    always @(negedge ref_clk) begin
        if (rd_seen) chk(rdata, expq.pop_front());
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0; ext_tick = 1'b0; gate_pin = 1'b1; bus_wr = 1'b0; bus_rd = 1'b0; ce = 1'b1;
        sleep_req = 1'b0; cmp_raw = 1'b1; cap_in = 1'b0; addr = 4'h0; wdata = 8'h00; rnd = 32'h17f3;
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        chk(vector, IRQ_VECTOR);
        bus(0, REG_CTRL, 8'h00);
        bus(0, REG_CC_CTL, 8'h00);
        bus(1, 4'hf, 8'hff);
        bus(0, 4'hf, 8'h00);
        // Gate pin high would block, but the gate is not enabled here
        rnd = lfsr(rnd);
        start = 16'h0000 - {13'h0000, rnd[2:0]} - 16'h0001;
        bus(1, REG_CNT_LO, start[7:0]);
        bus(1, REG_CNT_HI, start[15:8]);
        bus(1, REG_CTRL, 8'h03);
        tick(rnd[2:0] + 2);
        // Clock enable low: ticks arrive but nothing may move
        ce <= 1'b0;
        tick(2);
        ce <= 1'b1;
        bus(0, REG_CNT_LO, 8'h01);
        bus(0, REG_CNT_HI, 8'h00);
        bus(0, REG_FLAG, 8'h01);
        for (int m = 0; m < 8; m++) begin
            bus(1, REG_ENABLE, {7'h00, m[0]});
            bus(1, REG_IRQ_CTL, {m[2], m[1], 6'h00});
            idle(1);
            chk(irq, m == 7);
        end
        bus(1, REG_FLAG, 8'h00);
        bus(0, REG_FLAG, 8'h00);
        bus(1, REG_CTRL, 8'h02);
        tick(2);
        bus(0, REG_CNT_LO, 8'h01);
        for (int g = 0; g < 8; g++) begin
            // Pin and comparator disagree, so only the selected source can open the gate
            gate_pin <= g[0] ^ g[2];
            cmp_raw  <= g[0] ^ !g[2];
            bus(1, REG_CC_CTL, {5'h00, g[2], 2'h0});
            bus(1, REG_CNT_LO, 8'h00);
            bus(1, REG_CTRL, {g[1], 7'h43});
            tick(2);
            bus(0, REG_CNT_LO, (g[1] == g[0]) ? 8'h02 : 8'h00);
        end
        // Comparator gate resampled on the increment clock; its sampled level is high
        bus(1, REG_CC_CTL, 8'h0c);
        bus(1, REG_CNT_LO, 8'h00);
        tick(2);
        bus(0, REG_CNT_LO, 8'h02);
        sleep_req <= 1'b1;
        bus(1, REG_CTRL, 8'h03);
        bus(1, REG_CNT_LO, 8'hff);
        bus(1, REG_CNT_HI, 8'hff);
        tick(2);
        bus(0, REG_CNT_LO, 8'hff);
        bus(1, REG_CTRL, 8'h07);
        tick(1);
        idle(3);
        chk(wake_n, 1);
        chk(vgo_n, 1);
        chk(vec_seen, IRQ_VECTOR);
        sleep_req <= 1'b0;
        bus(1, REG_FLAG, 8'h00);
        bus(1, REG_CC_LO, 8'h05);
        bus(1, REG_CC_HI, 8'h00);
        bus(1, REG_CC_CTL, 8'h03);
        bus(1, REG_CTRL, 8'h03);
        tick(12);
        bus(0, REG_CNT_LO, 8'h02);
        chk(link.rollover_flag, 16'h0000);
        // The write lands on the edge where the stopped count matches
        rnd = lfsr(rnd);
        r8 = {rnd[7:1], 1'b1};
        bus(1, REG_CTRL, 8'h00);
        bus(1, REG_CC_LO, 8'h02);
        bus(1, REG_CNT_LO, r8);
        bus(0, REG_CNT_LO, r8);
        bus(1, REG_CC_CTL, 8'h01);
        cap_in <= 1'b1;
        idle(3);
        bus(0, REG_CC_LO, r8);
        bus(0, REG_CC_HI, 8'h00);
        cmp_n = 0;
        bus(1, REG_CC_CTL, 8'h02);
        idle(3);
        chk(cmp_n, 1);
        give_verdict();
    end
endmodule
`default_nettype wire
